// >>> common/status_consts.vh
// constants for the status and service request logic
// assumes it is included by bare name from the design file
`ifndef STATUS_CONSTS_VH
`define STATUS_CONSTS_VH

// register select codes on the command port
`define SEL_OPERATION_SUMMARY_COND      4'h0
`define SEL_OPERATION_SUMMARY_RISE      4'h1
`define SEL_OPERATION_SUMMARY_FALL      4'h2
`define SEL_OPERATION_SUMMARY_EVENT     4'h3
`define SEL_OPERATION_SUMMARY_MASK      4'h4
`define SEL_QUESTIONABLE_SUMMARY_COND      4'h5
`define SEL_QUESTIONABLE_SUMMARY_RISE      4'h6
`define SEL_QUESTIONABLE_SUMMARY_FALL      4'h7
`define SEL_QUESTIONABLE_SUMMARY_EVENT     4'h8
`define SEL_QUESTIONABLE_SUMMARY_MASK      4'h9
`define SEL_STD_EVENT      4'hA
`define SEL_STD_MASK       4'hB
`define SEL_STATUS_BYTE    4'hC
`define SEL_SRQ_MASK       4'hD
`define SEL_SERIAL_POLL    4'hE
`define SEL_OUT_QUEUE      4'hF
`define SEL_PSC            4'h0

// status byte bit positions
`define STB_QUESTIONABLE_SUMMARY_BIT       3
`define STB_MAV_BIT        4
`define STB_ESB_BIT        5
`define STB_MSS_BIT        6
`define STB_OPERATION_SUMMARY_BIT       7

// bit positions inside groups
`define STD_PON_BIT        7
`define OPERATION_SUMMARY_CC_BIT        10
`define QUESTIONABLE_SUMMARY_OV_BIT        0
`define QUESTIONABLE_SUMMARY_OC_BIT        1
`define QUESTIONABLE_SUMMARY_OT_BIT        4

// reset values, plus the service request enable bits in use
`define RST_FILTER         16'h0000
`define RST_MASK16         16'h0000
`define RST_EVENT16        16'h0000
`define RST_STD_EVENT      8'h80
`define RST_MASK8          8'h00
`define SRQ_MASK_USED      8'hBF

// output queue geometry
`define QUEUE_DEPTH        16
`define QUEUE_PTR_W        4

`endif

// >>> rtl/status_service_request_logic.v
// status groups, status byte summary and service request for an instrument
// assumes a command parser drives the select/strobe port on clk, condition
// lines arrive asynchronously from the monitored circuits, and an outside
// store holds the power-on-clear setting and standard mask across power loss
`timescale 1ns/100ps
`include "status_consts.vh"

// one 16-bit status group: sync, filters, event latch, mask
module status_group (
	input  wire        clk,
	input  wire        rst_n,
	input  wire [15:0] cond_pin,     // asynchronous condition lines
	input  wire        wr_rise,      // write rise filter
	input  wire        wr_fall,      // write fall filter
	input  wire        wr_mask,      // write enable mask
	input  wire        rd_event,     // event read, clears latch
	input  wire [15:0] wdata,        // write data
	output reg  [15:0] cond_r,       // accepted condition
	output reg  [15:0] rise_r,       // rising edge filter
	output reg  [15:0] fall_r,       // falling edge filter
	output reg  [15:0] event_r,      // event latch
	output reg  [15:0] mask_r,       // enable mask
	output wire        summary       // group summary bit
);
	reg  [15:0] sync1_r;             // first stage, read only by sync2_r
	reg  [15:0] sync2_r;             // second stage
	reg  [15:0] sync3_r;             // third stage
	wire [15:0] cond_nxt;            // condition after filtering glitches
	wire [15:0] rise_ev;             // passed rising transitions
	wire [15:0] fall_ev;             // passed falling transitions
	wire [15:0] event_nxt;           // next event latch

	// a bit changes only once stages two and three agree
	assign cond_nxt  = (sync2_r & sync3_r) | (cond_r & (sync2_r | sync3_r));
	assign rise_ev   = cond_nxt & ~cond_r & rise_r;
	assign fall_ev   = ~cond_nxt & cond_r & fall_r;
	// set beats clear so a change during the read is kept
	assign event_nxt = (rd_event ? 16'h0000 : event_r) | rise_ev | fall_ev;
	// live OR of enabled events; cleared event drops it at once
	assign summary   = |(event_r & mask_r);

	// synchroniser and condition register; no write path exists
	always @(posedge clk) begin
		if (!rst_n) begin
			sync1_r <= 16'h0000;
			sync2_r <= 16'h0000;
			sync3_r <= 16'h0000;
			cond_r  <= 16'h0000;
		end else begin
			sync1_r <= cond_pin;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			cond_r  <= cond_nxt;
		end
	end

	// filter, mask and event registers
	always @(posedge clk) begin
		if (!rst_n) begin
			rise_r  <= `RST_FILTER;
			fall_r  <= `RST_FILTER;
			mask_r  <= `RST_MASK16;
			event_r <= `RST_EVENT16;
		end else begin
			if (wr_rise) begin
				rise_r <= wdata;
			end
			if (wr_fall) begin
				fall_r <= wdata;
			end
			if (wr_mask) begin
				mask_r <= wdata;
			end
			event_r <= event_nxt;
		end
	end
endmodule

// top: both groups, standard events, status byte, queue, service request
module status_service_request_logic (
	input  wire        clk,
	input  wire        rst_n,
	input  wire [15:0] operation_summary_cond_pin,      // operation conditions, bit 10 constant current
	input  wire [15:0] questionable_summary_cond_pin,      // questionable conditions, bits 0,1,4 trips
	input  wire [7:0]  std_event_set,      // one-cycle standard event pulses
	input  wire        nv_psc,             // stored power-on-clear setting
	input  wire [7:0]  nv_std_mask,        // stored standard event mask
	input  wire [3:0]  sel,                // register select
	input  wire        wr_strobe,          // write request
	input  wire        psc_wr,             // write power-on-clear setting
	input  wire        rd_strobe,          // read request
	input  wire [15:0] wdata,              // write data
	input  wire        msg_valid,          // push a byte into the output queue
	input  wire [7:0]  msg_data,           // byte to push
	output reg         msg_ready_r,        // queue has room
	output reg  [15:0] rd_data_r,          // read answer
	output reg         rd_valid_r,         // read answer strobe
	output reg         srq_r,              // service request line, high asserts
	output reg         psc_r,              // power-on-clear setting for the store
	output reg  [7:0]  std_mask_r          // standard event mask for the store
);
	wire [15:0] operation_summary_cond;              // operation group registers
	wire [15:0] operation_summary_rise;
	wire [15:0] operation_summary_fall;
	wire [15:0] operation_summary_event;
	wire [15:0] operation_summary_mask;
	wire        operation_summary;
	wire [15:0] questionable_summary_cond;              // questionable group registers
	wire [15:0] questionable_summary_rise;
	wire [15:0] questionable_summary_fall;
	wire [15:0] questionable_summary_event;
	wire [15:0] questionable_summary_mask;
	wire        questionable_summary;
	reg  [7:0]  std_event_r;            // standard event latch, byte wide
	reg  [7:0]  srq_mask_r;             // service request enable
	reg         service_request_latched_r;
	reg         mss_d_r;                // master summary one cycle ago
	reg         restore_r;              // pending load from the store
	reg  [7:0]  queue_mem [0:`QUEUE_DEPTH-1]; // output message storage
	reg  [`QUEUE_PTR_W-1:0] wr_ptr_r;   // queue write pointer
	reg  [`QUEUE_PTR_W-1:0] rd_ptr_r;   // queue read pointer
	reg  [`QUEUE_PTR_W:0]   count_r;    // bytes held
	wire        wr_op;                  // write and read decode strobes
	wire        rd_op;
	wire        std_event_summary;
	wire        output_message_available;
	wire        master_summary;
	wire [7:0]  status_core;            // status byte without bit 6
	wire        q_push;
	wire        q_pop;
	wire        rqs_set;
	wire        rqs_clr;
	wire [7:0]  std_event_nxt;
	reg  [15:0] rd_mux;                 // combinational read selection

	assign wr_op = wr_strobe;
	assign rd_op = rd_strobe;

	// operation group; constant current arrives on bit 10
	status_group operation_summary_group (
		.clk      (clk),
		.rst_n    (rst_n),
		.cond_pin (operation_summary_cond_pin),
		.wr_rise  (wr_op && sel == `SEL_OPERATION_SUMMARY_RISE),
		.wr_fall  (wr_op && sel == `SEL_OPERATION_SUMMARY_FALL),
		.wr_mask  (wr_op && sel == `SEL_OPERATION_SUMMARY_MASK),
		.rd_event (rd_op && sel == `SEL_OPERATION_SUMMARY_EVENT),
		.wdata    (wdata),
		.cond_r   (operation_summary_cond),
		.rise_r   (operation_summary_rise),
		.fall_r   (operation_summary_fall),
		.event_r  (operation_summary_event),
		.mask_r   (operation_summary_mask),
		.summary  (operation_summary)
	);

	// questionable group; protection trips on bits 0, 1 and 4
	status_group questionable_summary_group (
		.clk      (clk),
		.rst_n    (rst_n),
		.cond_pin (questionable_summary_cond_pin),
		.wr_rise  (wr_op && sel == `SEL_QUESTIONABLE_SUMMARY_RISE),
		.wr_fall  (wr_op && sel == `SEL_QUESTIONABLE_SUMMARY_FALL),
		.wr_mask  (wr_op && sel == `SEL_QUESTIONABLE_SUMMARY_MASK),
		.rd_event (rd_op && sel == `SEL_QUESTIONABLE_SUMMARY_EVENT),
		.wdata    (wdata),
		.cond_r   (questionable_summary_cond),
		.rise_r   (questionable_summary_rise),
		.fall_r   (questionable_summary_fall),
		.event_r  (questionable_summary_event),
		.mask_r   (questionable_summary_mask),
		.summary  (questionable_summary)
	);

	// standard events: pulses set bits, read clears, set wins
	assign std_event_nxt = ((rd_op && sel == `SEL_STD_EVENT) ? 8'h00 : std_event_r)
		| std_event_set;
	assign std_event_summary = |(std_event_r & std_mask_r);
	assign output_message_available = (count_r != 5'h00);

	// status byte layout; bits 0..2 unused and read zero
	assign status_core = {operation_summary, 1'b0, std_event_summary,
		output_message_available, questionable_summary, 3'b000};
	// bit 6 of the enable is ignored so the summary cannot feed itself
	assign master_summary = |(status_core & srq_mask_r & `SRQ_MASK_USED);

	// request latches when the master summary rises; poll clears, set wins
	assign rqs_set = master_summary && !mss_d_r;
	assign rqs_clr = rd_op && sel == `SEL_SERIAL_POLL;

	// queue handshake: push only with room, pop on a queue read
	assign q_push = msg_valid && msg_ready_r;
	assign q_pop  = rd_op && sel == `SEL_OUT_QUEUE && output_message_available;

	// standard event latch; power-up always sets the power-on flag
	always @(posedge clk) begin
		if (!rst_n) begin
			std_event_r <= `RST_STD_EVENT;
		end else begin
			std_event_r <= std_event_nxt;
		end
	end

	// power-on-clear setting and, unless that setting is stored set, standard mask; restored after reset
	// release because a reset may only load constants
	always @(posedge clk) begin
		if (!rst_n) begin
			restore_r  <= 1'b1;
			psc_r      <= 1'b0;
			std_mask_r <= `RST_MASK8;
		end else if (restore_r) begin
			restore_r  <= 1'b0;
			psc_r      <= nv_psc;
			std_mask_r <= nv_psc ? `RST_MASK8 : nv_std_mask;
		end else begin
			if (psc_wr) begin
				psc_r <= wdata[0];
			end
			if (wr_op && sel == `SEL_STD_MASK) begin
				std_mask_r <= wdata[7:0];
			end
		end
	end

	// service request enable and latched request bit
	always @(posedge clk) begin
		if (!rst_n) begin
			srq_mask_r                <= `RST_MASK8;
			service_request_latched_r <= 1'b0;
			mss_d_r                   <= 1'b0;
			srq_r                     <= 1'b0;
		end else begin
			if (wr_op && sel == `SEL_SRQ_MASK) begin
				srq_mask_r <= wdata[7:0] & `SRQ_MASK_USED;
			end
			mss_d_r <= master_summary;
			if (rqs_set) begin
				service_request_latched_r <= 1'b1;
				srq_r                     <= 1'b1;
			end else if (rqs_clr) begin
				service_request_latched_r <= 1'b0;
				srq_r                     <= 1'b0;
			end
		end
	end

	// output queue, first in first out
	always @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr_r    <= 4'h0;
			rd_ptr_r    <= 4'h0;
			count_r     <= 5'h00;
			msg_ready_r <= 1'b1;
		end else begin
			if (q_push) begin
				queue_mem[wr_ptr_r] <= msg_data;
				wr_ptr_r            <= wr_ptr_r + 4'h1;
			end
			if (q_pop) begin
				rd_ptr_r <= rd_ptr_r + 4'h1;
			end
			case ({q_push, q_pop})
				2'b10: begin
					count_r     <= count_r + 5'h01;
					msg_ready_r <= (count_r != 5'h0F);
				end
				2'b01: begin
					count_r     <= count_r - 5'h01;
					msg_ready_r <= 1'b1;
				end
				default: begin
					count_r     <= count_r;
					msg_ready_r <= msg_ready_r;
				end
			endcase
		end
	end

	// read selection; unmapped codes cannot occur, all sixteen are used
	always @* begin
		rd_mux = 16'h0000;
		case (sel)
			`SEL_OPERATION_SUMMARY_COND:   rd_mux = operation_summary_cond;
			`SEL_OPERATION_SUMMARY_RISE:   rd_mux = operation_summary_rise;
			`SEL_OPERATION_SUMMARY_FALL:   rd_mux = operation_summary_fall;
			`SEL_OPERATION_SUMMARY_EVENT:  rd_mux = operation_summary_event;
			`SEL_OPERATION_SUMMARY_MASK:   rd_mux = operation_summary_mask;
			`SEL_QUESTIONABLE_SUMMARY_COND:   rd_mux = questionable_summary_cond;
			`SEL_QUESTIONABLE_SUMMARY_RISE:   rd_mux = questionable_summary_rise;
			`SEL_QUESTIONABLE_SUMMARY_FALL:   rd_mux = questionable_summary_fall;
			`SEL_QUESTIONABLE_SUMMARY_EVENT:  rd_mux = questionable_summary_event;
			`SEL_QUESTIONABLE_SUMMARY_MASK:   rd_mux = questionable_summary_mask;
			`SEL_STD_EVENT:   rd_mux = {8'h00, std_event_r};
			`SEL_STD_MASK:    rd_mux = {8'h00, std_mask_r};
			// query shows the live summary and leaves everything alone
			`SEL_STATUS_BYTE: rd_mux = {8'h00, status_core[7],
				master_summary, status_core[5:0]};
			`SEL_SRQ_MASK:    rd_mux = {8'h00, srq_mask_r};
			// poll shows the latched request bit instead
			`SEL_SERIAL_POLL: rd_mux = {8'h00, status_core[7],
				service_request_latched_r, status_core[5:0]};
			`SEL_OUT_QUEUE:   rd_mux = output_message_available ?
				{8'h00, queue_mem[rd_ptr_r]} : 16'h0000;
			default:          rd_mux = 16'h0000;
		endcase
	end

	// registered read answer, one cycle after the strobe
	always @(posedge clk) begin
		if (!rst_n) begin
			rd_data_r  <= 16'h0000;
			rd_valid_r <= 1'b0;
		end else begin
			rd_valid_r <= rd_op;
			if (rd_op) begin
				rd_data_r <= rd_mux;
			end
		end
	end
endmodule

// >>> verif/bus_controller.sv
// remote controller model issuing writes, queries and polls
// assumes the block takes a request at the edge where a strobe is high
`timescale 1ns/100ps
module bus_controller (
	input  wire        clk,
	input  wire [15:0] rd_data_r,
	input  wire        rd_valid_r,
	output reg  [3:0]  sel,
	output reg         wr_strobe,
	output reg         psc_wr,
	output reg         rd_strobe,
	output reg  [15:0] wdata
);
	// idle bus at time zero
	initial begin
		sel = 4'h0;
		wr_strobe = 1'b0;
		psc_wr = 1'b0;
		rd_strobe = 1'b0;
		wdata = 16'h0000;
	end
	// one write; p picks the setting port instead of the register port
	task wr(input [3:0] s, input [15:0] d, input p);
		begin
			@(posedge clk);
			sel <= s;
			wdata <= d;
			wr_strobe <= !p;
			psc_wr <= p;
			@(posedge clk);
			wr_strobe <= 1'b0;
			psc_wr <= 1'b0;
			wdata <= ~d; // stale data is not left on the bus
		end
	endtask
	// one read; a missing answer strobe yields unknown data
	task rd(input [3:0] s, output [15:0] d);
		begin
			@(posedge clk);
			sel <= s;
			rd_strobe <= 1'b1;
			@(posedge clk);
			rd_strobe <= 1'b0;
			#1;
			d = (rd_valid_r === 1'b1) ? rd_data_r : 16'hxxxx;
		end
	endtask
endmodule

// >>> verif/status_checker_properties.sv
// concurrent checks on the status and service request block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/100ps
`include "status_consts.vh"
module status_checker (
	input wire        clk,
	input wire        rst_n,
	input wire [3:0]  sel,
	input wire        wr_strobe,
	input wire        psc_wr,
	input wire        rd_strobe,
	input wire [15:0] wdata,
	input wire        msg_valid,
	input wire        msg_ready_r,
	input wire [15:0] rd_data_r,
	input wire        rd_valid_r,
	input wire        srq_r,
	input wire        psc_r,
	input wire [7:0]  std_mask_r
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire rd_c = rd_strobe && sel == `SEL_STATUS_BYTE; // status byte query
	wire rd_e = rd_strobe && sel == `SEL_SERIAL_POLL; // serial poll
	wire rd_b = rd_strobe && sel >= `SEL_STD_EVENT && sel <= `SEL_SERIAL_POLL; // byte regs
	// every read is answered by a one-cycle strobe
	rd_pulse_a: assert property (rd_strobe |=> rd_valid_r)
		else $error("read not answered");
	// unused status byte bits read as zero
	stb_zero_a: assert property (rd_c |=> rd_data_r[2:0] == 3'h0)
		else $error("status byte low bits set");
	// byte wide registers leave the upper half clear
	byte_regs_a: assert property (rd_b |=> rd_data_r[15:8] == 8'h00)
		else $error("byte register upper half set");
	// a poll returns the request bit and clears it
	poll_clear_a: assert property (rd_e && srq_r |=> rd_data_r[6] && !srq_r)
		else $error("poll did not return or clear request");
	// the request line only drops through a poll
	srq_drop_a: assert property ($fell(srq_r) |-> $past(rd_e))
		else $error("request dropped without poll");
	// a full queue must show message available
	full_mav_a: assert property (rd_c && !msg_ready_r |=> rd_data_r[4])
		else $error("full queue without message bit");
	// room only vanishes after a push
	ready_fall_a: assert property ($fell(msg_ready_r) |-> $past(msg_valid))
		else $error("queue filled without push");
	// the first cycle after reset belongs to the restore, so skip it
	mask_store_a: assert property (wr_strobe && sel == `SEL_STD_MASK && $past(rst_n)
		|=> std_mask_r == $past(wdata[7:0]))
		else $error("standard mask not written");
	// setting reaches the store port one edge later
	psc_store_a: assert property (psc_wr |=> psc_r == $past(wdata[0]))
		else $error("power-on-clear setting not written");
	cover property ($rose(srq_r));
	cover property (rd_e && srq_r);
	cover property ($fell(msg_ready_r));
endmodule
bind status_service_request_logic status_checker i_chk (
	.clk(clk), .rst_n(rst_n), .sel(sel), .wr_strobe(wr_strobe), .psc_wr(psc_wr),
	.rd_strobe(rd_strobe), .wdata(wdata), .msg_valid(msg_valid), .msg_ready_r(msg_ready_r),
	.rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r), .srq_r(srq_r), .psc_r(psc_r),
	.std_mask_r(std_mask_r));

// >>> verif/testbench.sv
// self-checking bench for the status and service request block
// assumes the controller model and the bound checker are compiled alongside
`timescale 1ns/100ps
`include "status_consts.vh"
module testbench;
	reg         clk;
	reg         rst_n;
	reg  [15:0] operation_summary_cond_pin;
	reg  [15:0] questionable_summary_cond_pin;
	reg  [7:0]  std_event_set;
	reg         nv_psc;
	reg  [7:0]  nv_std_mask;
	reg         msg_valid;
	reg  [7:0]  msg_data;
	wire [3:0]  sel;
	wire        wr_strobe;
	wire        psc_wr;
	wire        rd_strobe;
	wire [15:0] wdata;
	wire [15:0] rd_data_r;
	wire        rd_valid_r;
	wire        msg_ready_r;
	wire        srq_r;
	wire        psc_r;
	wire [7:0]  std_mask_r;
	integer     bad_count;
	integer     n_checks;
	integer     cyc;
	integer     i;
	reg  [15:0] got;
	status_service_request_logic i_dut (.clk(clk), .rst_n(rst_n),
		.operation_summary_cond_pin(operation_summary_cond_pin), .questionable_summary_cond_pin(questionable_summary_cond_pin),
		.std_event_set(std_event_set), .nv_psc(nv_psc), .nv_std_mask(nv_std_mask),
		.sel(sel), .wr_strobe(wr_strobe), .psc_wr(psc_wr), .rd_strobe(rd_strobe),
		.wdata(wdata), .msg_valid(msg_valid), .msg_data(msg_data),
		.msg_ready_r(msg_ready_r), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
		.srq_r(srq_r), .psc_r(psc_r), .std_mask_r(std_mask_r));
	bus_controller i_ctl (.clk(clk), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
		.sel(sel), .wr_strobe(wr_strobe), .psc_wr(psc_wr), .rd_strobe(rd_strobe),
		.wdata(wdata));
	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// a hang counts as a mismatch
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 4000) begin
			bad_count = bad_count + 1;
			final_report;
		end
	end
	task chk(input string nm, input [15:0] e, input [15:0] g);
		begin
			n_checks = n_checks + 1;
			if (g !== e) begin
				bad_count = bad_count + 1;
				$display("Error %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task rq(input [3:0] s, input [15:0] e);
		begin
			i_ctl.rd(s, got);
			chk($sformatf("register %h", s), e, got);
		end
	endtask
	task w(input [3:0] s, input [15:0] d);
		i_ctl.wr(s, d, 1'b0);
	endtask
	// move the condition lines and let the synchronisers settle
	task pin(input [15:0] o, input [15:0] q);
		begin
			@(posedge clk);
			operation_summary_cond_pin <= o;
			questionable_summary_cond_pin <= q;
			repeat (8) @(posedge clk);
		end
	endtask
	task do_reset;
		begin
			rst_n <= 1'b0;
			repeat (8) @(posedge clk);
			rst_n <= 1'b1;
			repeat (3) @(posedge clk);
		end
	endtask
	task final_report;
		begin
			$display("checks %0d mismatches %0d", n_checks, bad_count);
			if (bad_count == 0 && n_checks > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	initial begin
		rst_n = 1'b0;
		operation_summary_cond_pin = 16'h0000;
		questionable_summary_cond_pin = 16'h0000;
		std_event_set = 8'h00;
		nv_psc = 1'b0;
		nv_std_mask = 8'h80;
		msg_valid = 1'b0;
		msg_data = 8'h00;
		bad_count = 0;
		n_checks = 0;
		cyc = 0;
		do_reset;
		// power-up flag raises a request through the standard summary
		rq(`SEL_STD_MASK, 16'h0080);
		w(`SEL_SRQ_MASK, 16'h0020);
		rq(`SEL_STATUS_BYTE, 16'h0060);
		rq(`SEL_STATUS_BYTE, 16'h0060);
		chk("srq", 16'h0001, {15'h0000, srq_r});
		rq(`SEL_SERIAL_POLL, 16'h0060);
		chk("srq", 16'h0000, {15'h0000, srq_r});
		rq(`SEL_SERIAL_POLL, 16'h0020);
		rq(`SEL_STD_EVENT, 16'h0080);
		rq(`SEL_STD_EVENT, 16'h0000);
		rq(`SEL_STATUS_BYTE, 16'h0000);
		@(posedge clk);
		std_event_set <= 8'h04;
		@(posedge clk);
		std_event_set <= 8'h00;
		rq(`SEL_STD_EVENT, 16'h0004);
		$display("test power-up done");
		// operation group: read-only condition, filters, mask, both edges
		w(`SEL_OPERATION_SUMMARY_COND, 16'hFFFF);
		rq(`SEL_OPERATION_SUMMARY_COND, 16'h0000);
		w(`SEL_OPERATION_SUMMARY_RISE, 16'h0400);
		rq(`SEL_OPERATION_SUMMARY_RISE, 16'h0400);
		w(`SEL_OPERATION_SUMMARY_MASK, 16'h0400);
		w(`SEL_SRQ_MASK, 16'h0088);
		pin(16'h0400, 16'h0000);
		rq(`SEL_OPERATION_SUMMARY_COND, 16'h0400);
		chk("srq", 16'h0001, {15'h0000, srq_r});
		w(`SEL_OPERATION_SUMMARY_MASK, 16'h0000);
		rq(`SEL_STATUS_BYTE, 16'h0000);
		w(`SEL_OPERATION_SUMMARY_MASK, 16'h0400);
		rq(`SEL_STATUS_BYTE, 16'h00C0);
		rq(`SEL_OPERATION_SUMMARY_EVENT, 16'h0400);
		rq(`SEL_OPERATION_SUMMARY_EVENT, 16'h0000);
		rq(`SEL_SERIAL_POLL, 16'h0040);
		pin(16'h0000, 16'h0000);
		rq(`SEL_OPERATION_SUMMARY_EVENT, 16'h0000);
		w(`SEL_OPERATION_SUMMARY_FALL, 16'h0400);
		pin(16'h0400, 16'h0000);
		rq(`SEL_OPERATION_SUMMARY_EVENT, 16'h0400);
		pin(16'h0000, 16'h0000);
		rq(`SEL_OPERATION_SUMMARY_EVENT, 16'h0400);
		$display("test operation group done");
		// questionable group: the three protection trips
		w(`SEL_QUESTIONABLE_SUMMARY_RISE, 16'h0013);
		w(`SEL_QUESTIONABLE_SUMMARY_MASK, 16'h0013);
		pin(16'h0000, 16'h0013);
		rq(`SEL_STATUS_BYTE, 16'h0048);
		rq(`SEL_QUESTIONABLE_SUMMARY_COND, 16'h0013);
		rq(`SEL_QUESTIONABLE_SUMMARY_EVENT, 16'h0013);
		rq(`SEL_STATUS_BYTE, 16'h0000);
		$display("test questionable group done");
		// output queue: fill until refused, drain in order, then empty
		for (i = 0; i < 16; i = i + 1) begin
			@(posedge clk);
			msg_valid <= 1'b1;
			msg_data <= 8'hA0 + i[7:0];
		end
		@(posedge clk);
		msg_valid <= 1'b0;
		#1;
		chk("ready", 16'h0000, {15'h0000, msg_ready_r});
		rq(`SEL_STATUS_BYTE, 16'h0010);
		for (i = 0; i < 16; i = i + 1)
			rq(`SEL_OUT_QUEUE, {8'h00, 8'hA0 + i[7:0]});
		rq(`SEL_OUT_QUEUE, 16'h0000);
		rq(`SEL_STATUS_BYTE, 16'h0000);
		$display("test output queue done");
		// power-on-clear setting wipes the stored mask over a second reset
		w(`SEL_STD_MASK, 16'h00FF);
		i_ctl.wr(`SEL_PSC, 16'h0001, 1'b1);
		rq(`SEL_STD_MASK, 16'h00FF);
		chk("psc", 16'h0001, {15'h0000, psc_r});
		nv_psc <= 1'b1;
		nv_std_mask <= 8'hFF;
		do_reset;
		rq(`SEL_STD_MASK, 16'h0000);
		rq(`SEL_STD_EVENT, 16'h0080);
		$display("test power-on clear done");
		final_report;
	end
endmodule
